// ==== link_error_irq_pkg.sv ====
package link_error_irq_pkg;

  // ----------------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------------
  // Each register index sits in one aligned 32-bit word at four times its index.
  localparam logic [7:0] CTRL_INDEX   = 8'hE0;
  localparam logic [7:0] ENABLE_INDEX = 8'hE1;
  localparam logic [7:0] STATUS_INDEX = 8'hE5;
  localparam logic [7:0] CLEAR_INDEX  = 8'hE6;
  localparam int         ADDR_LSB     = 2;
  localparam int         DECODE_BITS  = 10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int IRQ_ENABLE_BIT   = 0;
  localparam int SYNC_BIT         = 7;
  localparam int CHECKSUM_BIT     = 6;
  localparam int UNCORRECTED_BIT  = 5;
  localparam int CORRECTED_BIT    = 4;
  localparam int PROTOCOL_BIT     = 3;
  localparam int LEADER_BIT       = 2;
  localparam int RESERVED_BIT     = 1;
  localparam int UNLOCK_BIT       = 0;

  // ----------------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] ENABLE_RESET    = 8'h00;
  localparam logic [7:0] STATUS_RESET    = 8'h01;
  localparam logic [7:0] CTRL_WRITABLE   = 8'h01;
  localparam logic [7:0] ENABLE_WRITABLE = 8'hFD;
  localparam logic [7:0] STATUS_WRITABLE = 8'hFD;

  // ----------------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'h0;

endpackage

// ==== level_sync.sv ====
`timescale 1ns/10ps

// Three-stage synchroniser; the output follows only when stages two and three agree.
module level_sync (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Level from the foreign domain
  input  wire logic async_level,
  output logic      stable_level
);

  typedef struct packed {
    logic first;
    logic second;
    logic third;
    logic level;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  // The first stage feeds only the second, so no logic sees a metastable value.
  always_comb begin
    next_state        = state;
    next_state.first  = async_level;
    next_state.second = state.first;
    next_state.third  = state.second;
    if (state.second == state.third) begin
      next_state.level = state.third;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign stable_level = state.level;

endmodule // level_sync

// ==== status_flag.sv ====
`timescale 1ns/10ps

// One sticky status bit: hardware sets it, software clears it, and a set wins.
module status_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Set and clear requests
  input  wire logic set,
  input  wire logic clear,
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } flag_state_type;

  flag_state_type state;
  flag_state_type next_state;

  // A set in the cycle of a clear keeps the bit, so no event is lost.
  always_comb begin
    next_state = state;
    if (set) begin
      next_state.flag = 1'b1;
    end else if (clear) begin
      next_state.flag = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '{flag: RESET_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;

endmodule // status_flag

// ==== link_error_irq_unit.sv ====
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// R1 - Output enable clear keeps interrupt pin undriven.
// R2 - Enabled pin high when enabled status set.
// R3 - Mask bit 7 gates unexpected sync error.
// R4 - Mask bit 6 gates payload checksum error.
// R5 - Mask bit 5 gates uncorrectable header error.
// R6 - Mask bit 4 gates corrected header error.
// R7 - Mask bit 3 gates low-level protocol error.
// R8 - Mask bit 2 gates start leader error.
// R9 - Mask bit 0 gates lock loss; bit1 reserved.
// R10 - Errors set status; writing one clears it.
// R11 - Lock-to-unlock sets bit 0, resets to one.
// R12 - Protocol bit collects all low-level sync errors.
// R13 - Status sets regardless of mask bits.
// R14 - Reserved bits read zero, ignore writes.
module link_error_irq_unit (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Error pulses from the packet processor
  input  wire logic        unexpected_sync_error,
  input  wire logic        payload_checksum_error,
  input  wire logic        header_uncorrectable_error,
  input  wire logic        header_corrected_error,
  input  wire logic        start_leader_bit_error,
  // Low-level protocol error sources
  input  wire logic        sot_eot_sync_error,
  input  wire logic        escape_entry_error,
  input  wire logic        lp_sync_error,
  input  wire logic        false_control_error,
  input  wire logic        lane_merge_error,
  // PLL lock level from the PLL domain
  input  wire logic        pll_locked,
  // Interrupt pin
  output logic             irq_pin_out,
  output logic             irq_pin_oe
);

  import link_error_irq_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic       wr_pending;
    logic       rd_pending;
    logic [7:0] index;
    logic       lock_prev;
  } unit_state_type;

  unit_state_type state;
  unit_state_type next_state;

  logic [7:0] set_vec;
  logic [7:0] clear_vec;
  logic [7:0] status;
  logic       lock_stable;
  logic       low_level_protocol_error;
  logic       accept;
  logic       index_hit;
  logic [7:0] addr_index;

  // ----------------------------------------------------------------------
  // Lock monitor
  // ----------------------------------------------------------------------
  // The lock level comes from another clock, so it is filtered before use.
  level_sync lock_sync (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .async_level  (pll_locked),
    .stable_level (lock_stable)
  );

  // ----------------------------------------------------------------------
  // Event collection
  // ----------------------------------------------------------------------
  // Every low-level sync fault lands on one status bit. [R12]
  assign low_level_protocol_error = sot_eot_sync_error | escape_entry_error | lp_sync_error |
                                    false_control_error | lane_merge_error;

  // Events set status bits with no regard to the mask register. [R10] [R13]
  always_comb begin
    set_vec                  = 8'h00;
    set_vec[SYNC_BIT]        = unexpected_sync_error;
    set_vec[CHECKSUM_BIT]    = payload_checksum_error;
    set_vec[UNCORRECTED_BIT] = header_uncorrectable_error;
    set_vec[CORRECTED_BIT]   = header_corrected_error;
    set_vec[PROTOCOL_BIT]    = low_level_protocol_error;
    set_vec[LEADER_BIT]      = start_leader_bit_error;
    set_vec[UNLOCK_BIT]      = state.lock_prev & ~lock_stable; // [R11]
  end

  // Writing one to the status word or to the clear word clears; zeros are ignored. [R10]
  always_comb begin
    clear_vec = 8'h00;
    if (state.wr_pending && (state.index == STATUS_INDEX || state.index == CLEAR_INDEX)) begin
      clear_vec = hwdata[7:0] & STATUS_WRITABLE;
    end
  end

  // ----------------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------------
  // The unlock bit starts set, since the PLL is not locked out of reset. [R11]
  for (genvar i = 0; i < 8; i++) begin : g_status
    if (i == RESERVED_BIT) begin : g_reserved
      assign status[i] = 1'b0; // [R14]
    end else begin : g_flag
      status_flag #(
        .RESET_VALUE (STATUS_RESET[i])
      ) flag_bit (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (set_vec[i]),
        .clear   (clear_vec[i]),
        .flag    (status[i])
      );
    end
  end

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  // Only whole-word transfers are taken; others complete as OKAY with no effect.
  assign addr_index = haddr[DECODE_BITS-1:ADDR_LSB];
  assign accept     = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
  assign index_hit  = (addr_index == CTRL_INDEX) || (addr_index == ENABLE_INDEX) ||
                      (addr_index == STATUS_INDEX) || (addr_index == CLEAR_INDEX);

  // Address phase captures the target, the data phase applies the write.
  always_comb begin
    next_state            = state;
    next_state.lock_prev  = lock_stable;
    next_state.wr_pending = accept & hwrite & index_hit;
    next_state.rd_pending = accept & ~hwrite & index_hit;
    if (accept) begin
      next_state.index = addr_index;
    end
    if (state.wr_pending && state.index == CTRL_INDEX) begin
      next_state.ctrl = hwdata[7:0] & CTRL_WRITABLE; // [R1] [R14]
    end
    if (state.wr_pending && state.index == ENABLE_INDEX) begin
      // Bits 7 to 2 and 0 are masks; bit 1 stays zero. [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R14]
      next_state.mask = hwdata[7:0] & ENABLE_WRITABLE;
    end
  end

  // State register; all controls come up cleared, so the pin is undriven. [R1] [R9]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '{ctrl: CTRL_RESET, mask: ENABLE_RESET, wr_pending: 1'b0, rd_pending: 1'b0,
                 index: 8'h00, lock_prev: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // Read data is a mux of registers; the clear word and unmapped words read zero. [R14]
  always_comb begin
    hrdata = 32'h0000_0000;
    if (state.rd_pending) begin
      unique case (state.index)
        CTRL_INDEX:   hrdata[7:0] = state.ctrl;
        ENABLE_INDEX: hrdata[7:0] = state.mask;
        STATUS_INDEX: hrdata[7:0] = status;
        default:      hrdata      = 32'h0000_0000;
      endcase
    end
  end

  // The unit never stalls, so every transfer takes one data cycle.
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  // ----------------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------------
  // The pin is driven only when enabled, and then high for any masked-in status. [R1] [R2]
  assign irq_pin_oe  = state.ctrl[IRQ_ENABLE_BIT];
  assign irq_pin_out = |(status & state.mask); // [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R13]

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking chk_clk @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence write_to(logic [7:0] idx);
    state.wr_pending && state.index == idx;
  endsequence

  sequence quiet_bus;
    !state.wr_pending;
  endsequence

  chk_ctrl_off_undriven: assert property ( // [R1]
    write_to(CTRL_INDEX) ##0 !hwdata[0] |=> !irq_pin_oe)
    else $error("Interrupt pin still driven after enable cleared.");

  chk_enabled_pin_high: assert property ( // [R2]
    (state.ctrl[0] && status[SYNC_BIT] && state.mask[SYNC_BIT]) |-> (irq_pin_oe && irq_pin_out))
    else $error("Enabled pending interrupt not driven high.");

  chk_sync_event_irq: assert property ( // [R3]
    (unexpected_sync_error && state.mask[SYNC_BIT] && state.ctrl[0]) ##0 quiet_bus
      |=> irq_pin_out && irq_pin_oe)
    else $error("Enabled sync error did not raise the interrupt.");

  chk_checksum_masked: assert property ( // [R4]
    (status == 8'h40 && !state.mask[CHECKSUM_BIT]) |-> !irq_pin_out)
    else $error("Masked checksum error raised the interrupt.");

  chk_status_w1c: assert property ( // [R10]
    write_to(STATUS_INDEX) ##0 (set_vec == 8'h00)
      |=> status == ($past(status) & ~($past(hwdata[7:0]) & STATUS_WRITABLE)))
    else $error("Status clear did not follow write-one-to-clear.");

  chk_event_sets_bits: assert property ( // [R10]
    (set_vec != 8'h00) |=> ((status & $past(set_vec)) == $past(set_vec)))
    else $error("Error event did not set its status bit.");

  chk_unlock_sets_bit: assert property ( // [R11]
    (state.lock_prev && !lock_stable) |=> status[UNLOCK_BIT])
    else $error("Lock loss did not set the unlock bit.");

  chk_lane_merge_bit: assert property ( // [R12]
    lane_merge_error |=> status[PROTOCOL_BIT])
    else $error("Lane merge error not reported as protocol error.");

  chk_mask_free_set: assert property ( // [R13]
    (payload_checksum_error && !state.mask[CHECKSUM_BIT]) |=> status[CHECKSUM_BIT])
    else $error("Masked source did not set its status bit.");

  chk_reserved_reads_zero: assert property ( // [R14]
    state.rd_pending |-> (hrdata[31:8] == 24'h000000 && !status[RESERVED_BIT] &&
                          !state.mask[RESERVED_BIT] && state.ctrl[7:1] == 7'h00))
    else $error("Reserved bits read non-zero.");

  // A source event with its mask and the pin enable set, and no write landing that could change them.
  sequence enabled_event(logic ev, int pos);
    ev && state.mask[pos] && state.ctrl[IRQ_ENABLE_BIT] && !state.wr_pending;
  endsequence

  // One status bit pending by itself while its mask bit is clear.
  sequence lone_masked(int pos);
    status == 8'(1 << pos) && !state.mask[pos];
  endsequence

  chk_reset_pin_off: assert property ( // [R1]
    $rose(hresetn) |-> (!irq_pin_oe && !irq_pin_out))
    else $error("Interrupt pin driven right after reset.");

  chk_ctrl_on_drives: assert property ( // [R1]
    write_to(CTRL_INDEX) ##0 hwdata[IRQ_ENABLE_BIT] |=> irq_pin_oe)
    else $error("Interrupt pin not driven after enable set.");

  chk_any_enabled_high: assert property ( // [R2]
    (state.ctrl[IRQ_ENABLE_BIT] && (status & state.mask) != 8'h00) |-> (irq_pin_oe && irq_pin_out))
    else $error("Enabled pending source did not drive the pin high.");

  chk_sync_masked_off: assert property ( // [R3]
    lone_masked(SYNC_BIT) |-> !irq_pin_out)
    else $error("Masked sync error raised the interrupt.");

  chk_checksum_event_irq: assert property ( // [R4]
    enabled_event(payload_checksum_error, CHECKSUM_BIT) |=> (irq_pin_out && irq_pin_oe))
    else $error("Enabled checksum error did not raise the interrupt.");

  chk_uncorr_event_irq: assert property ( // [R5]
    enabled_event(header_uncorrectable_error, UNCORRECTED_BIT) |=> (irq_pin_out && irq_pin_oe))
    else $error("Enabled uncorrectable header error did not raise the interrupt.");

  chk_uncorr_masked_off: assert property ( // [R5]
    lone_masked(UNCORRECTED_BIT) |-> !irq_pin_out)
    else $error("Masked uncorrectable header error raised the interrupt.");

  chk_corr_event_irq: assert property ( // [R6]
    enabled_event(header_corrected_error, CORRECTED_BIT) |=> (irq_pin_out && irq_pin_oe))
    else $error("Enabled corrected header event did not raise the interrupt.");

  chk_corr_masked_off: assert property ( // [R6]
    lone_masked(CORRECTED_BIT) |-> !irq_pin_out)
    else $error("Masked corrected header event raised the interrupt.");

  chk_protocol_event_irq: assert property ( // [R7]
    enabled_event(low_level_protocol_error, PROTOCOL_BIT) |=> (irq_pin_out && irq_pin_oe))
    else $error("Enabled protocol error did not raise the interrupt.");

  chk_protocol_masked_off: assert property ( // [R7]
    lone_masked(PROTOCOL_BIT) |-> !irq_pin_out)
    else $error("Masked protocol error raised the interrupt.");

  chk_leader_event_irq: assert property ( // [R8]
    enabled_event(start_leader_bit_error, LEADER_BIT) |=> (irq_pin_out && irq_pin_oe))
    else $error("Enabled leader bit error did not raise the interrupt.");

  chk_leader_masked_off: assert property ( // [R8]
    lone_masked(LEADER_BIT) |-> !irq_pin_out)
    else $error("Masked leader bit error raised the interrupt.");

  chk_unlock_enabled_irq: assert property ( // [R9]
    (status[UNLOCK_BIT] && state.mask[UNLOCK_BIT] && state.ctrl[IRQ_ENABLE_BIT]) |-> (irq_pin_out && irq_pin_oe))
    else $error("Enabled lock loss did not raise the interrupt.");

  chk_unlock_masked_off: assert property ( // [R9]
    lone_masked(UNLOCK_BIT) |-> !irq_pin_out)
    else $error("Masked lock loss raised the interrupt.");

  chk_clear_word_w1c: assert property ( // [R10]
    write_to(CLEAR_INDEX) ##0 (set_vec == 8'h00)
      |=> status == ($past(status) & ~($past(hwdata[7:0]) & STATUS_WRITABLE)))
    else $error("Clear word did not follow write-one-to-clear.");

  chk_status_holds: assert property ( // [R10]
    (set_vec == 8'h00 && clear_vec == 8'h00) |=> $stable(status))
    else $error("Status changed with no event and no clear.");

  chk_unlock_reset_one: assert property ( // [R11]
    $rose(hresetn) |-> status[UNLOCK_BIT])
    else $error("Unlock bit not set after reset.");

  chk_unlock_needs_fall: assert property ( // [R11]
    (!status[UNLOCK_BIT] && !(state.lock_prev && !lock_stable)) |=> !status[UNLOCK_BIT])
    else $error("Unlock bit set with no lock loss.");

  chk_protocol_sources: assert property ( // [R12]
    (sot_eot_sync_error || escape_entry_error || lp_sync_error || false_control_error) |=> status[PROTOCOL_BIT])
    else $error("Low-level sync fault not reported as protocol error.");

  chk_mask_reserved_zero: assert property ( // [R14] [R9]
    write_to(ENABLE_INDEX) |=> (!state.mask[RESERVED_BIT] && state.mask[UNLOCK_BIT] == $past(hwdata[UNLOCK_BIT])))
    else $error("Enable write changed the reserved bit or missed the unlock mask.");

endmodule // link_error_irq_unit

// ==== error_source_model.sv ====
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Packet processor and PLL stand-in
// ----------------------------------------------------------------------
module error_source_model (
  // Clock
  input  wire logic       hclk,
  // Requests from the bench
  input  wire logic [9:0] fire_req,
  input  wire logic       lock_req,
  // Toward the unit
  output logic [9:0]      error_pulse,
  output logic            pll_lock_level
);
  // Start quiet so the unit never sees an unknown error level.
  initial begin
    error_pulse    = '0;
    pll_lock_level = 1'b0;
  end

  // Each detector output is registered, so a request becomes a one-cycle pulse.
  always @(posedge hclk) begin
    error_pulse <= fire_req;
  end

  // The lock level moves off the register clock phase, as a foreign domain would.
  always @(lock_req) begin
    pll_lock_level <= #3 lock_req;
  end
endmodule // error_source_model

// ==== link_error_irq_unit_test.sv ====
`timescale 1ns/10ps

module link_error_irq_unit_test;
  import link_error_irq_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and reference state
  // ----------------------------------------------------------------------
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lock_req = 0;
  logic        hready, hreadyout, hresp, irq_pin_out, irq_pin_oe, pll_locked;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = HSIZE_WORD, sz = HSIZE_WORD;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [9:0]  fire_req = '0, ev;
  int          n_errors = 0, cmp_count = 0, st, en, ctl;
  int          bitpos[10] = '{7, 6, 5, 4, 2, 3, 3, 3, 3, 3};
  localparam logic [31:0] A_CTL = {22'h0, CTRL_INDEX, 2'h0};
  localparam logic [31:0] A_EN  = {22'h0, ENABLE_INDEX, 2'h0};
  localparam logic [31:0] A_ST  = {22'h0, STATUS_INDEX, 2'h0};
  localparam logic [31:0] A_CLR = {22'h0, CLEAR_INDEX, 2'h0};
  localparam logic [31:0] A_BAD = 32'h000003A0;

  // Clock, and the single slave closes the bus ready loop.
  always #5 hclk = ~hclk;
  assign hready = hreadyout;

  link_error_irq_unit u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .unexpected_sync_error(ev[0]), .payload_checksum_error(ev[1]),
    .header_uncorrectable_error(ev[2]), .header_corrected_error(ev[3]),
    .start_leader_bit_error(ev[4]), .sot_eot_sync_error(ev[5]),
    .escape_entry_error(ev[6]), .lp_sync_error(ev[7]),
    .false_control_error(ev[8]), .lane_merge_error(ev[9]),
    .pll_locked(pll_locked), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe)
  );

  error_source_model u_src (
    .hclk(hclk), .fire_req(fire_req), .lock_req(lock_req),
    .error_pulse(ev), .pll_lock_level(pll_locked)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single transfer; waits on ready rather than assuming a latency.
  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr_en;
    hsize  <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'(HRESP_OKAY), {31'h0, hresp});
  endtask

  // Writes also update the reference; reserved bits are dropped here.
  task automatic wr(input logic [31:0] a, input int d);
    bus(1'b1, a, d);
    if (a == A_CTL) ctl = d & 1;
    if (a == A_EN) en = d & 'hFD;
    if (a == A_ST || a == A_CLR) st = st & ~d;
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a, input int exp);
    bus(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // One edge passes first, so a write that landed at the last edge shows on the pin.
  task automatic irqchk();
    @(posedge hclk);
    chk("irq_pin_out", 32'(|(st & en)), {31'h0, irq_pin_out});
    chk("irq_pin_oe", 32'(ctl[0]), {31'h0, irq_pin_oe});
  endtask

  // The pulse lands one edge late and sets status at the next edge.
  task automatic fire(input logic [9:0] v);
    fire_req <= v;
    @(posedge hclk);
    fire_req <= '0;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 10; i++) if (v[i]) st = st | (1 << bitpos[i]);
  endtask

  task automatic done_test(input string nm);
    $display("test %s finished, %0d mismatches so far", nm, n_errors);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------------
  // About five hundred cycles are expected; twenty thousand means a hang.
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    $display("Error watchdog expected finish seen hang");
    summarize();
  end

  initial begin
    void'($urandom(32'hB71A));
    st  = 1;
    en  = 0;
    ctl = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("control", A_CTL, 0);
    rdchk("enable", A_EN, 0);
    rdchk("status", A_ST, 1);
    rdchk("clear", A_CLR, 0);
    rdchk("unmapped", A_BAD, 0);
    irqchk();
    done_test("reset");
    wr(A_CTL, 'hFF);
    wr(A_EN, 'hFF);
    rdchk("control", A_CTL, ctl);
    rdchk("enable", A_EN, en);
    irqchk();
    wr(A_ST, 'h00);
    rdchk("status", A_ST, st);
    wr(A_ST, 'hFF);
    rdchk("status", A_ST, st);
    done_test("access");
    // Each source alone, first enabled and then masked.
    for (int i = 0; i < 10; i++) begin
      wr(A_EN, 1 << bitpos[i]);
      fire(10'(1 << i));
      irqchk();
      rdchk("status", A_ST, st);
      wr(A_EN, ~(1 << bitpos[i]) & 'hFF);
      irqchk();
      wr(A_CLR, 'hFF);
      irqchk();
    end
    wr(A_EN, 0);
    fire(10'h3FF);
    rdchk("status", A_ST, st);
    irqchk();
    done_test("sources");
    repeat (20) begin
      wr(A_EN, $urandom & 'hFF);
      wr(A_CTL, $urandom & 'h3);
      fire(10'($urandom));
      irqchk();
      wr(A_ST, $urandom & 'hFF);
      rdchk("status", A_ST, st);
    end
    done_test("random");
    wr(A_CTL, 1);
    wr(A_EN, 1);
    wr(A_CLR, 'hFF);
    lock_req <= 1'b1;
    repeat (10) @(posedge hclk);
    rdchk("status", A_ST, st);
    lock_req <= 1'b0;
    repeat (10) @(posedge hclk);
    st = st | 1;
    rdchk("status", A_ST, st);
    irqchk();
    done_test("lock");
    // A byte-sized write must leave the control register alone.
    sz = 3'h0;
    bus(1'b1, A_CTL, 32'h0);
    sz = HSIZE_WORD;
    rdchk("control", A_CTL, ctl);
    done_test("size");
    // Reset again in mid-run, with the pin enabled and the unlock source unmasked.
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    st  = 1;
    en  = 0;
    ctl = 0;
    irqchk();
    rdchk("status", A_ST, st);
    rdchk("control", A_CTL, ctl);
    rdchk("enable", A_EN, en);
    done_test("reset again");
    summarize();
  end
endmodule // link_error_irq_unit_test
